// ### src/dbq_cfg.svh
// dbq_cfg.svh: offsets, reset values and piece counts of the queue pair
`ifndef DBQ_CFG_SVH
`define DBQ_CFG_SVH

// ****************************************************************
// offset choices for almost-full / almost-empty
// ****************************************************************
`define DBQ_OFFSET_HH 7'h10
`define DBQ_OFFSET_HL 7'h0c
`define DBQ_OFFSET_LH 7'h08
`define DBQ_OFFSET_LL 7'h04
`define DBQ_OFFSET_RESET 7'h04

// ****************************************************************
// reset values of flags and drivers
// ****************************************************************
`define DBQ_FULL_N_RESET 1'b0
`define DBQ_EMPTY_N_RESET 1'b0
`define DBQ_AE_N_RESET 1'b0
`define DBQ_AF_N_RESET 1'b1
`define DBQ_MAIL_N_RESET 1'b1
`define DBQ_OE_N_RESET 1'b1

// ****************************************************************
// pieces that follow the first one of a long word on port b
// ****************************************************************
`define DBQ_BYTE_MORE 2'h3
`define DBQ_WORD_MORE 2'h1
`define DBQ_LONG_MORE 2'h0

`endif

// ### src/dbq_pkg.sv
// dbq_pkg.sv: types shared by the queue pair
package dbq_pkg;
    // port b bus size, coded as {size_high, size_low}
    typedef enum logic [1:0] {
        DBQ_SIZE_LONG,
        DBQ_SIZE_BYTE,
        DBQ_SIZE_WORD,
        DBQ_SIZE_MAIL
    } dbq_size_t;
endpackage : dbq_pkg

// ### src/dbq_queue.sv
// dbq_queue.sv: one queue, flip-flop storage with read and write pointers
module dbq_queue #(
    parameter int WIDTH = 36,
    parameter int ADDR_W = 6
) (
    input wire logic ref_clk, // system clock
    input wire logic clear, // synchronous clear of pointers
    input wire logic wr_en, // store wr_data this cycle
    input wire logic [WIDTH-1:0] wr_data, // word to store
    input wire logic rd_en, // advance past head word
    output logic [ADDR_W:0] wr_ptr, // write pointer, one wrap bit
    output logic [ADDR_W:0] rd_ptr, // read pointer, one wrap bit
    output logic [WIDTH-1:0] rd_data // head word
);
    logic [WIDTH-1:0] mem [2**ADDR_W];

    // storage needs no reset: nothing reads a slot before it is written
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_ptr[ADDR_W-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clear) begin
            wr_ptr <= '0;
        end else if (wr_en) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clear) begin
            rd_ptr <= '0;
        end else if (rd_en) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

    assign rd_data = mem[rd_ptr[ADDR_W-1:0]];

    property p_both_taken;
        @(posedge ref_clk) disable iff (clear)
        wr_en && rd_en |=> (wr_ptr - rd_ptr) == $past(wr_ptr - rd_ptr)
            && wr_ptr != $past(wr_ptr);
    endproperty
    a_both_taken: assert property (p_both_taken)
        else $error("simultaneous write and read not both taken");
endmodule : dbq_queue

// ### src/dbq_ptr_sync.sv
// dbq_ptr_sync.sv: carries a pointer over two stages clocked by port edges
module dbq_ptr_sync #(
    parameter int W = 7
) (
    input wire logic ref_clk, // system clock
    input wire logic clear, // synchronous clear
    input wire logic tick, // rising edge of the receiving port clock
    input wire logic [W-1:0] d, // pointer from the far side
    output logic [W-1:0] q, // pointer after two port edges
    output logic q_valid // two port edges seen since clear
);
    logic [W-1:0] stage1;
    logic valid1;

    // a pointer that moves in the same cycle as tick is caught one edge later
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            stage1 <= '0;
            valid1 <= 1'b0;
        end else if (tick) begin
            stage1 <= d;
            valid1 <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clear) begin
            q <= '0;
            q_valid <= 1'b0;
        end else if (tick) begin
            q <= stage1;
            q_valid <= valid1;
        end
    end

    property p_moves_on_tick;
        @(posedge ref_clk) disable iff (clear)
        !tick ##1 !clear |-> $stable(q) && $stable(q_valid);
    endproperty
    a_moves_on_tick: assert property (p_moves_on_tick)
        else $error("synchronised pointer moved without a port edge");
endmodule : dbq_ptr_sync

// ### src/dbq_top.sv
// dbq_top.sv: two opposite 36-bit queues between port a and port b with flags
// ****************************************************************
// ****************************************************************
`include "dbq_cfg.svh"

module dbq_top #(
    parameter int WIDTH = 36,
    parameter int ADDR_W = 6
) (
    input wire logic ref_clk, // system clock, 100 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic dev_reset_n, // device reset pin, active low
    input wire logic offset_select_low, // offset select, low bit
    input wire logic offset_select_high, // offset select, high bit
    input wire logic port_a_clock, // port a clock, sampled
    input wire logic port_a_select_n, // port a chip select
    input wire logic port_a_write_not_read, // port a direction
    input wire logic port_a_enable, // port a transfer enable
    input wire logic port_a_mailbox_select, // port a mailbox select
    input wire logic [WIDTH-1:0] port_a_data_in, // port a pin level
    output logic [WIDTH-1:0] port_a_data_out, // port a output register
    output logic port_a_data_oe_n, // port a driver enable
    output logic port_a_full_n, // a-to-b queue full
    output logic port_a_almost_full_n, // a-to-b queue almost full
    output logic port_a_empty_n, // b-to-a queue empty
    output logic port_a_almost_empty_n, // b-to-a queue almost empty
    input wire logic port_b_clock, // port b clock, sampled
    input wire logic port_b_select_n, // port b chip select
    input wire logic port_b_write_not_read, // port b direction
    input wire logic port_b_enable, // port b transfer enable
    input wire logic port_b_size_low, // port b bus size, low bit
    input wire logic port_b_size_high, // port b bus size, high bit
    input wire logic [WIDTH-1:0] port_b_data_in, // port b pin level
    output logic [WIDTH-1:0] port_b_data_out, // port b output register
    output logic port_b_data_oe_n, // port b driver enable
    output logic port_b_full_n, // b-to-a queue full
    output logic port_b_almost_full_n, // b-to-a queue almost full
    output logic port_b_empty_n, // a-to-b queue empty
    output logic port_b_almost_empty_n, // a-to-b queue almost empty
    output logic mail_one_flag_n, // mail one flag, held high
    output logic mail_two_flag_n // mail two flag, held high
);
    localparam int LVL_W = ADDR_W + 1;
    localparam int DEPTH = 2**ADDR_W;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [LVL_W-1:0] fill(input logic [LVL_W-1:0] head,
                                             input logic [LVL_W-1:0] tail);
        return LVL_W'(head - tail);
    endfunction : fill

    function automatic logic [LVL_W-1:0] offset_of(input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b11: return LVL_W'(`DBQ_OFFSET_HH);
            2'b10: return LVL_W'(`DBQ_OFFSET_HL);
            2'b01: return LVL_W'(`DBQ_OFFSET_LH);
            2'b00: return LVL_W'(`DBQ_OFFSET_LL);
        endcase
    endfunction : offset_of

    function automatic logic [WIDTH-1:0] low_piece(input logic [WIDTH-1:0] w,
                                                  input dbq_pkg::dbq_size_t s);
        unique case (s)
            dbq_pkg::DBQ_SIZE_BYTE: return {{(WIDTH-WIDTH/4){1'b0}}, w[WIDTH/4-1:0]};
            dbq_pkg::DBQ_SIZE_WORD: return {{(WIDTH-WIDTH/2){1'b0}}, w[WIDTH/2-1:0]};
            dbq_pkg::DBQ_SIZE_LONG: return w;
            dbq_pkg::DBQ_SIZE_MAIL: return w;
        endcase
    endfunction : low_piece

    function automatic logic [WIDTH-1:0] rest_of(input logic [WIDTH-1:0] w,
                                                input dbq_pkg::dbq_size_t s);
        unique case (s)
            dbq_pkg::DBQ_SIZE_BYTE: return w >> (WIDTH/4);
            dbq_pkg::DBQ_SIZE_WORD: return w >> (WIDTH/2);
            dbq_pkg::DBQ_SIZE_LONG: return '0;
            dbq_pkg::DBQ_SIZE_MAIL: return '0;
        endcase
    endfunction : rest_of

    function automatic logic [1:0] more_of(input dbq_pkg::dbq_size_t s);
        unique case (s)
            dbq_pkg::DBQ_SIZE_BYTE: return `DBQ_BYTE_MORE;
            dbq_pkg::DBQ_SIZE_WORD: return `DBQ_WORD_MORE;
            dbq_pkg::DBQ_SIZE_LONG: return `DBQ_LONG_MORE;
            dbq_pkg::DBQ_SIZE_MAIL: return `DBQ_LONG_MORE;
        endcase
    endfunction : more_of

    // ****************************************************************
    // edges, reset and offset
    // ****************************************************************
    logic a_clk_q, b_clk_q, rst_n_q;
    logic a_tick, b_tick, dev_clear, rst_rise;
    logic [LVL_W-1:0] offset_x;

    assign a_tick = port_a_clock & ~a_clk_q;
    assign b_tick = port_b_clock & ~b_clk_q;
    // the device pin works as a second, synchronous clear
    assign dev_clear = srst | ~dev_reset_n;
    assign rst_rise = dev_reset_n & ~rst_n_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            a_clk_q <= 1'b0;
            b_clk_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            a_clk_q <= port_a_clock;
            b_clk_q <= port_b_clock;
            rst_n_q <= dev_reset_n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            offset_x <= LVL_W'(`DBQ_OFFSET_RESET);
        end else if (rst_rise) begin
            offset_x <= offset_of(offset_select_high, offset_select_low);
        end
    end

    // ****************************************************************
    // queues and pointer crossing
    // ****************************************************************
    logic [LVL_W-1:0] ab_wr_ptr, ab_rd_ptr, ba_wr_ptr, ba_rd_ptr;
    logic [LVL_W-1:0] ab_wr_at_b, ab_rd_at_a, ba_wr_at_a, ba_rd_at_b;
    logic ab_wr_at_b_v, ab_rd_at_a_v, ba_wr_at_a_v, ba_rd_at_b_v;
    logic [WIDTH-1:0] ab_head, ba_head;
    logic a_wr_go, a_rd_go, b_wr_go, b_rd_sel, b_pop, b_more;
    dbq_pkg::dbq_size_t b_size, b_size_q;

    dbq_queue #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_a_to_b_queue (
        .ref_clk(ref_clk),
        .clear(dev_clear),
        .wr_en(a_wr_go),
        .wr_data(port_a_data_in),
        .rd_en(b_pop),
        .wr_ptr(ab_wr_ptr),
        .rd_ptr(ab_rd_ptr),
        .rd_data(ab_head)
    );

    dbq_queue #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_b_to_a_queue (
        .ref_clk(ref_clk),
        .clear(dev_clear),
        .wr_en(b_wr_go),
        .wr_data(port_b_data_in),
        .rd_en(a_rd_go),
        .wr_ptr(ba_wr_ptr),
        .rd_ptr(ba_rd_ptr),
        .rd_data(ba_head)
    );

    // each far pointer takes two edges of the port that owns the flag
    dbq_ptr_sync #(.W(LVL_W)) u_ab_wr_to_b (
        .ref_clk(ref_clk), .clear(dev_clear), .tick(b_tick),
        .d(ab_wr_ptr), .q(ab_wr_at_b), .q_valid(ab_wr_at_b_v)
    );
    dbq_ptr_sync #(.W(LVL_W)) u_ab_rd_to_a (
        .ref_clk(ref_clk), .clear(dev_clear), .tick(a_tick),
        .d(ab_rd_ptr), .q(ab_rd_at_a), .q_valid(ab_rd_at_a_v)
    );
    dbq_ptr_sync #(.W(LVL_W)) u_ba_wr_to_a (
        .ref_clk(ref_clk), .clear(dev_clear), .tick(a_tick),
        .d(ba_wr_ptr), .q(ba_wr_at_a), .q_valid(ba_wr_at_a_v)
    );
    dbq_ptr_sync #(.W(LVL_W)) u_ba_rd_to_b (
        .ref_clk(ref_clk), .clear(dev_clear), .tick(b_tick),
        .d(ba_rd_ptr), .q(ba_rd_at_b), .q_valid(ba_rd_at_b_v)
    );

    // ****************************************************************
    // flag conditions
    // ****************************************************************
    logic a_full_c, a_af_c, a_empty_c, a_ae_c;
    logic b_full_c, b_af_c, b_empty_c, b_ae_c;
    logic [1:0] b_pieces, next_b_pieces;

    // valid bits hold reset values until two edges of the own clock
    always_comb begin
        a_full_c = ab_rd_at_a_v && fill(ab_wr_ptr, ab_rd_at_a) != LVL_W'(DEPTH);
        a_af_c = !ab_rd_at_a_v
            || fill(ab_wr_ptr, ab_rd_at_a) < LVL_W'(LVL_W'(DEPTH) - offset_x);
        a_empty_c = ba_wr_at_a_v && ba_wr_at_a != ba_rd_ptr;
        a_ae_c = ba_wr_at_a_v && fill(ba_wr_at_a, ba_rd_ptr) > offset_x;
        b_full_c = ba_rd_at_b_v && fill(ba_wr_ptr, ba_rd_at_b) != LVL_W'(DEPTH);
        b_af_c = !ba_rd_at_b_v
            || fill(ba_wr_ptr, ba_rd_at_b) < LVL_W'(LVL_W'(DEPTH) - offset_x);
        b_empty_c = ab_wr_at_b_v && ab_wr_at_b != ab_rd_ptr;
        b_ae_c = ab_wr_at_b_v && fill(ab_wr_at_b, ab_rd_ptr) > offset_x;
    end

    always_ff @(posedge ref_clk) begin
        if (dev_clear) begin
            port_a_full_n <= `DBQ_FULL_N_RESET;
            port_a_almost_full_n <= `DBQ_AF_N_RESET;
            port_a_empty_n <= `DBQ_EMPTY_N_RESET;
            port_a_almost_empty_n <= `DBQ_AE_N_RESET;
            port_b_full_n <= `DBQ_FULL_N_RESET;
            port_b_almost_full_n <= `DBQ_AF_N_RESET;
            port_b_empty_n <= `DBQ_EMPTY_N_RESET;
            port_b_almost_empty_n <= `DBQ_AE_N_RESET;
            mail_one_flag_n <= `DBQ_MAIL_N_RESET;
            mail_two_flag_n <= `DBQ_MAIL_N_RESET;
        end else begin
            port_a_full_n <= a_full_c;
            port_a_almost_full_n <= a_af_c;
            port_a_empty_n <= a_empty_c;
            port_a_almost_empty_n <= a_ae_c;
            port_b_full_n <= b_full_c;
            port_b_almost_full_n <= b_af_c;
            // stays high until the last piece of a long word is out
            port_b_empty_n <= b_empty_c | (next_b_pieces != 2'h0);
            port_b_almost_empty_n <= b_ae_c;
        end
    end

    // ****************************************************************
    // port a transfers
    // ****************************************************************
    // flags only change on own edges, so the pin value is current at a_tick
    assign a_wr_go = a_tick & ~port_a_select_n & port_a_write_not_read & port_a_enable
        & ~port_a_mailbox_select & port_a_full_n;
    assign a_rd_go = a_tick & ~port_a_select_n & ~port_a_write_not_read & port_a_enable
        & ~port_a_mailbox_select & port_a_empty_n;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_a_data_out <= '0;
        end else if (a_rd_go) begin
            port_a_data_out <= ba_head;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_a_data_oe_n <= `DBQ_OE_N_RESET;
        end else begin
            port_a_data_oe_n <= port_a_select_n | port_a_write_not_read;
        end
    end

    // ****************************************************************
    // port b transfers and bus sizing
    // ****************************************************************
    logic [WIDTH-1:0] b_hold;

    assign b_size = dbq_pkg::dbq_size_t'({port_b_size_high, port_b_size_low});
    assign b_wr_go = b_tick & ~port_b_select_n & port_b_write_not_read & port_b_enable
        & (b_size != dbq_pkg::DBQ_SIZE_MAIL) & port_b_full_n;
    assign b_rd_sel = b_tick & ~port_b_select_n & ~port_b_write_not_read & port_b_enable
        & (b_size != dbq_pkg::DBQ_SIZE_MAIL);
    assign b_more = b_rd_sel & (b_pieces != 2'h0);
    assign b_pop = b_rd_sel & (b_pieces == 2'h0) & port_b_empty_n;

    always_comb begin
        next_b_pieces = b_pieces;
        if (dev_clear) begin
            next_b_pieces = 2'h0;
        end else if (b_pop) begin
            next_b_pieces = more_of(b_size);
        end else if (b_more) begin
            next_b_pieces = b_pieces - 2'h1;
        end
    end

    // size is held per long word; a change mid-word takes effect on the next one
    always_ff @(posedge ref_clk) begin
        if (dev_clear) begin
            b_pieces <= 2'h0;
            b_size_q <= dbq_pkg::DBQ_SIZE_LONG;
            b_hold <= '0;
        end else begin
            b_pieces <= next_b_pieces;
            if (b_pop) begin
                b_size_q <= b_size;
                b_hold <= rest_of(ab_head, b_size);
            end else if (b_more) begin
                b_hold <= rest_of(b_hold, b_size_q);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_b_data_out <= '0;
        end else if (b_pop) begin
            port_b_data_out <= low_piece(ab_head, b_size);
        end else if (b_more) begin
            port_b_data_out <= low_piece(b_hold, b_size_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_b_data_oe_n <= `DBQ_OE_N_RESET;
        end else begin
            port_b_data_oe_n <= port_b_select_n | port_b_write_not_read;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_reset_flags;
        @(posedge ref_clk) dev_clear |=> !port_a_full_n && !port_b_full_n
            && !port_a_empty_n && !port_b_empty_n && !port_a_almost_empty_n
            && !port_b_almost_empty_n && port_a_almost_full_n && port_b_almost_full_n
            && mail_one_flag_n && mail_two_flag_n;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("flags wrong after device reset");

    property p_full_after_reset;
        @(posedge ref_clk) disable iff (dev_clear)
        $rose(port_a_full_n) |-> $past(ab_rd_at_a_v);
    endproperty
    a_full_after_reset: assert property (p_full_after_reset)
        else $error("port a full flag rose before two port a edges");

    property p_offset_load;
        @(posedge ref_clk) disable iff (srst)
        rst_rise |=> offset_x == $past(offset_of(offset_select_high, offset_select_low));
    endproperty
    a_offset_load: assert property (p_offset_load)
        else $error("offset not loaded on reset release");

    property p_a_drive;
        @(posedge ref_clk) disable iff (srst)
        !port_a_select_n && !port_a_write_not_read |=> !port_a_data_oe_n;
    endproperty
    a_a_drive: assert property (p_a_drive)
        else $error("port a not driving on read select");

    property p_b_release;
        @(posedge ref_clk) disable iff (srst)
        port_b_select_n || port_b_write_not_read |=> port_b_data_oe_n;
    endproperty
    a_b_release: assert property (p_b_release)
        else $error("port b driving while deselected");

    property p_a_write;
        @(posedge ref_clk) disable iff (srst)
        a_wr_go && !b_pop && !dev_clear |=>
            fill(ab_wr_ptr, ab_rd_ptr) == LVL_W'($past(fill(ab_wr_ptr, ab_rd_ptr)) + 1'b1);
    endproperty
    a_a_write: assert property (p_a_write)
        else $error("port a write did not add one word");

    property p_no_enable;
        @(posedge ref_clk) disable iff (dev_clear)
        !port_a_enable |=> $stable(ab_wr_ptr) && $stable(ba_rd_ptr);
    endproperty
    a_no_enable: assert property (p_no_enable)
        else $error("transfer on port a with enable low");

    property p_full_block;
        @(posedge ref_clk) disable iff (dev_clear)
        !port_b_full_n |=> $stable(ba_wr_ptr);
    endproperty
    a_full_block: assert property (p_full_block)
        else $error("write taken while port b full flag low");

    property p_empty_block;
        @(posedge ref_clk) disable iff (dev_clear)
        !port_a_empty_n |=> $stable(ba_rd_ptr) && $stable(port_a_data_out);
    endproperty
    a_empty_block: assert property (p_empty_block)
        else $error("read taken while port a empty flag low");

    property p_byte_pieces;
        @(posedge ref_clk) disable iff (dev_clear)
        b_pop && b_size == dbq_pkg::DBQ_SIZE_BYTE |=> b_pieces == `DBQ_BYTE_MORE
            && port_b_empty_n;
    endproperty
    a_byte_pieces: assert property (p_byte_pieces)
        else $error("byte read did not leave three pieces pending");
endmodule : dbq_top

// ### test/dbq_port_clk.sv
// dbq_port_clk.sv: far-side port clocks as sampled levels
module dbq_port_clk #(
    parameter int HALF_A = 2, // port a half period, ref cycles
    parameter int HALF_B = 3 // port b half period, ref cycles
) (
    input wire logic ref_clk, // system clock
    output logic clk_a, // port a clock
    output logic clk_b // port b clock
);
    timeunit 1ns;
    timeprecision 1ns;
    int ca = 0;
    int cb = 0;
    // unequal rates keep the two port edges drifting apart
    initial begin
        clk_a = 1'b0;
        clk_b = 1'b0;
    end
    always @(posedge ref_clk) begin
        #1;
        ca = (ca + 1) % HALF_A;
        cb = (cb + 1) % HALF_B;
        if (ca == 0) clk_a = ~clk_a;
        if (cb == 0) clk_b = ~clk_b;
    end
endmodule : dbq_port_clk

// ### test/dbq_top_test.sv
// dbq_top_test.sv: queue model bench for the two-way queue pair
module dbq_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic rst_n = 1'b0;
    logic [1:0] sel_n = 2'h3, wnr = 2'h0, en = 2'h0, pclk, oe_n, full_n, empty_n, aempty_n;
    logic [1:0] afull_n, siz = 2'h0, fs = 2'h0;
    logic mail1, mail2, mbx = 1'b0;
    logic [35:0] part = 36'h0;
    int left = 0;
    int x_off = 4;
    logic [35:0] din [2] = '{36'h0, 36'h0};
    logic [35:0] dout [2];
    logic [35:0] last [2] = '{36'h0, 36'h0};
    logic [35:0] q [2][$];
    int seed = 32'h3605;
    int n_mismatch = 0;
    int n_compared = 0;
    dbq_port_clk clk_u (.ref_clk(ref_clk), .clk_a(pclk[0]), .clk_b(pclk[1]));
    dbq_top dut_u (.ref_clk(ref_clk), .srst(srst), .dev_reset_n(rst_n),
        .offset_select_low(fs[0]), .offset_select_high(fs[1]), .port_a_clock(pclk[0]),
        .port_a_select_n(sel_n[0]), .port_a_write_not_read(wnr[0]), .port_a_enable(en[0]),
        .port_a_mailbox_select(mbx), .port_a_data_in(din[0]), .port_a_data_out(dout[0]),
        .port_a_data_oe_n(oe_n[0]), .port_a_full_n(full_n[0]),
        .port_a_almost_full_n(afull_n[0]),
        .port_a_empty_n(empty_n[0]), .port_a_almost_empty_n(aempty_n[0]),
        .port_b_clock(pclk[1]), .port_b_select_n(sel_n[1]), .port_b_write_not_read(wnr[1]),
        .port_b_enable(en[1]), .port_b_size_low(siz[0]), .port_b_size_high(siz[1]),
        .port_b_data_in(din[1]), .port_b_data_out(dout[1]), .port_b_data_oe_n(oe_n[1]),
        .port_b_full_n(full_n[1]), .port_b_almost_full_n(afull_n[1]),
        .port_b_empty_n(empty_n[1]),
        .port_b_almost_empty_n(aempty_n[1]), .mail_one_flag_n(mail1), .mail_two_flag_n(mail2));
    initial forever #5 ref_clk = ~ref_clk;
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    // one transfer on port p, set up while its clock is low so no edge is missed
    task op(input int p, input logic w, input logic e, input logic [35:0] d);
        while (pclk[p] !== 1'b1) @(posedge ref_clk);
        while (pclk[p] !== 1'b0) @(posedge ref_clk);
        #1 sel_n[p] = 1'b0;
        wnr[p] = w;
        en[p] = e;
        din[p] = d;
        @(posedge pclk[p]);
        @(posedge ref_clk);
        #1 en[p] = 1'b0;
        chk(36'(oe_n[p]), 36'(w));
        // 64 long words deep; mailbox accesses never reach the queue
        if (w && e && !(p == 0 && mbx) && q[p].size() < 64) q[p].push_back(d);
        if (!w) begin
            // byte reads on port b hand out 9-bit pieces, low piece first
            if (e && left > 0) begin
                part = part >> 9;
                left--;
                last[p] = 36'(part[8:0]);
            end else if (e && q[1-p].size() > 0) begin
                part = q[1-p].pop_front();
                left = (p == 1 && siz == 2'h1) ? 3 : 0;
                last[p] = (left > 0) ? 36'(part[8:0]) : part;
            end
            chk(dout[p], last[p]);
        end
    endtask : op
    task wait_data(input int p);
        for (int i = 0; i < 80 && aempty_n[p] !== 1'b1 && empty_n[p] !== 1'b1; i++)
            @(posedge ref_clk);
        #1 chk(36'(empty_n[p]), 36'h1);
    endtask : wait_data
    // device reset held long enough for four edges of both port clocks
    task dev_reset(input logic [1:0] f, input int x);
        rst_n = 1'b0;
        fs = f;
        x_off = x;
        repeat (30) @(posedge ref_clk);
        #1 chk(36'({full_n, empty_n, aempty_n, afull_n, mail1, mail2}), 36'hf);
        rst_n = 1'b1;
        for (int i = 0; i < 40 && full_n !== 2'h3; i++) @(posedge ref_clk);
        #1 chk(36'(full_n), 36'h3);
    endtask : dev_reset
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 srst = 1'b0;
        chk(36'({full_n, empty_n, aempty_n, afull_n, mail1, mail2}), 36'hf);
        dev_reset(2'h0, 4);
        $display("reset test done");
        mbx = 1'b1;
        op(0, 1'b1, 1'b1, 36'h3c3c3c3c3);
        mbx = 1'b0;
        for (int i = 0; i < 5; i++) op(0, 1'b1, 1'b1, 36'({$random(seed), $random(seed)}));
        wait_data(1);
        repeat (40) @(posedge ref_clk);
        chk(36'(aempty_n[1]), 36'h1);
        for (int i = 0; i < 2; i++) op(1, 1'b1, 1'b1, 36'({$random(seed), $random(seed)}));
        op(1, 1'b1, 1'b0, 36'h5a5a5a5a5);
        for (int i = 0; i < 5; i++) op(1, 1'b0, 1'b1, 36'h0);
        wait_data(0);
        for (int i = 0; i < 3; i++) op(0, 1'b0, 1'b1, 36'h0);
        $display("transfer test done");
        // second reset mid-run with another offset, then fill to the brim
        dev_reset(2'h2, 12);
        for (int i = 1; i <= 65; i++) begin
            op(0, 1'b1, 1'b1, 36'({$random(seed), $random(seed)}));
            if (i == x_off || i == x_off + 1 || i == 63 - x_off
                    || i == 64 - x_off || i == 65) begin
                repeat (20) @(posedge ref_clk);
                #1 chk(36'({aempty_n[1], afull_n[0], full_n[0]}),
                    36'({i > x_off, i < 64 - x_off, i < 64}));
            end
        end
        op(1, 1'b0, 1'b1, 36'h0);
        for (int i = 0; i < 20 && full_n[0] !== 1'b1; i++) @(posedge ref_clk);
        #1 chk(36'(full_n[0]), 36'h1);
        for (int i = 0; i < 62; i++) op(1, 1'b0, 1'b1, 36'h0);
        siz = 2'h1;
        for (int i = 0; i < 5; i++) begin
            op(1, 1'b0, 1'b1, 36'h0);
            chk(36'(empty_n[1]), 36'(i < 3));
        end
        $display("fill test done");
        print_verdict();
    end
    initial begin
        #300000;
        n_mismatch++;
        print_verdict();
    end
endmodule : dbq_top_test
